//--- rtl/cihs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "cihs_regs.svh"

module cihs_sequencer (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Core instruction boundary
  input wire logic instrEnd,
  input wire logic [2:0] instrKind,
  input wire logic [15:0] nextPc,
  input wire logic [7:0] statusWord,
  input wire logic skipPending,
  // Core control
  output logic cpuClkEn,
  output logic haltMode,
  output logic interruptEnableFf,
  output logic pcLoad,
  output logic [15:0] pcValue,
  output logic swLoad,
  output logic [7:0] swValue,
  // Stack access
  output logic stackPush,
  output logic [7:0] stackData,
  output logic stackPop,
  input wire logic [7:0] popData,
  // Interrupt sources
  input wire logic nmiN,
  input wire logic extIrqA,
  input wire logic extIrqBN,
  input wire logic [7:0] periphReq,
  // Register port
  input wire logic [1:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  // Expansion bus pins
  input wire logic extMode,
  input wire logic dataOeIn,
  input wire logic wrNIn,
  input wire logic rdNIn,
  input wire logic aleIn,
  input wire logic [7:0] addrIn,
  output logic dataOe,
  output logic wrN,
  output logic rdN,
  output logic ale,
  output logic [7:0] addrOut
);

  localparam logic [3:0] FILT_N =
    4'((`CIHS_FILT_CYC < `CIHS_NMI_MAX_CYC) ? `CIHS_FILT_CYC : `CIHS_NMI_MAX_CYC);
  localparam logic [4:0] SAVE_LAST = 5'(`CIHS_SAVE_CYC - 1);

  cihs_pkg::cihs_st_t st;
  cihs_pkg::cihs_st_t next_st;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [3:0] prioIdx(input logic [9:0] req);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 9; i >= 0; i--) begin
      if (req[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  function automatic logic [15:0] vecOf(input logic [3:0] idx);
    return `CIHS_VEC_BASE + 16'(idx) * `CIHS_VEC_STEP;
  endfunction

  function automatic logic [15:0] readMux(input logic [1:0] a, input cihs_pkg::cihs_st_t s,
    input logic halted);
    logic [15:0] d;
    d = 16'h0000;
    unique case (a)
      `CIHS_REG_MASK: begin
        d = {6'h00, s.mask};
      end
      `CIHS_REG_FLAGS: begin
        d = {5'h00, s.nmiFlag, s.flags};
      end
      `CIHS_REG_STAT: begin
        d = {12'h000, s.state, s.ie, halted};
      end
      default: begin
        d = 16'h0000;
      end
    endcase
    return d;
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic [2:0] act;
  logic [2:0] hit;
  logic [9:0] setF;
  logic [9:0] clrF;
  logic [9:0] pend;
  logic [3:0] idx;
  logic nmiSet;
  logic nmiClr;
  logic anyReq;

  always_comb begin
    next_st = st;
    next_st.stackPush = 1'b0;
    next_st.stackPop = 1'b0;
    next_st.pcLoad = 1'b0;
    next_st.swLoad = 1'b0;
    next_st.regRdata = 16'h0000;
    clrF = 10'h000;
    nmiClr = 1'b0;

    // ----------------------------------------
    // Pin noise filters
    // ----------------------------------------
    act = {~extIrqBN, extIrqA, ~nmiN};
    hit = 3'b000;
    for (int i = 0; i < 3; i++) begin
      if (!act[i]) begin
        next_st.filt[i] = 4'h0;
        next_st.fired[i] = 1'b0;
      end else if (!st.fired[i]) begin
        if (st.filt[i] == FILT_N - 4'h1) begin
          hit[i] = 1'b1;
          next_st.fired[i] = 1'b1;
        end else begin
          next_st.filt[i] = st.filt[i] + 4'h1;
        end
      end
    end
    nmiSet = hit[0];
    setF = {periphReq, hit[2], hit[1]};

    // ----------------------------------------
    // Pending requests
    // ----------------------------------------
    pend = st.flags & ~st.mask;
    anyReq = st.nmiFlag | (|pend);
    idx = prioIdx(pend);

    // ----------------------------------------
    // Register port
    // ----------------------------------------
    if (regWr) begin
      unique case (regAddr)
        `CIHS_REG_MASK: begin
          next_st.mask = regWdata[9:0];
        end
        `CIHS_REG_FLAGS: begin
          clrF = regWdata[9:0];
          nmiClr = regWdata[10];
        end
        default: begin
        end
      endcase
    end
    if (regRd) begin
      next_st.regRdata = readMux(regAddr, st, haltMode);
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    unique case (st.state)
      cihs_pkg::CIHS_RUN: begin
        if (instrEnd) begin
          next_st.retAddr = nextPc;
          next_st.saveSw = statusWord;
          next_st.cnt = 5'h00;
          if (st.nmiFlag) begin
            nmiClr = 1'b1;
            next_st.ie = 1'b0;
            next_st.vec = `CIHS_VEC_NMI;
            next_st.state = cihs_pkg::CIHS_SAVE;
          end else if (instrKind == cihs_pkg::CIHS_K_TRAP) begin
            // Taken even with a pending skip
            if (skipPending) begin
              next_st.saveSw[`CIHS_SK_BIT] = 1'b1;
            end
            next_st.vec = `CIHS_VEC_TRAP;
            next_st.state = cihs_pkg::CIHS_SAVE;
          end else if (st.ie && (|pend)) begin
            clrF[idx] = 1'b1;
            next_st.ie = 1'b0;
            next_st.vec = vecOf(idx);
            next_st.state = cihs_pkg::CIHS_SAVE;
          end else if (instrKind == cihs_pkg::CIHS_K_RETURN_FROM_INTERRUPT_INSTR) begin
            next_st.stackPop = 1'b1;
            next_st.state = cihs_pkg::CIHS_POP;
          end else if (instrKind == cihs_pkg::CIHS_K_HALT) begin
            if (!anyReq) begin
              next_st.state = cihs_pkg::CIHS_HALT;
            end
          end else if (instrKind == cihs_pkg::CIHS_K_EI) begin
            next_st.ie = 1'b1;
          end else if (instrKind == cihs_pkg::CIHS_K_DI) begin
            next_st.ie = 1'b0;
          end
        end
      end
      cihs_pkg::CIHS_SAVE: begin
        next_st.cnt = st.cnt + 5'h01;
        if (st.cnt == 5'h00) begin
          next_st.stackPush = 1'b1;
          next_st.stackData = st.saveSw;
        end else if (st.cnt == 5'h01) begin
          next_st.stackPush = 1'b1;
          next_st.stackData = st.retAddr[15:8];
        end else if (st.cnt == 5'h02) begin
          next_st.stackPush = 1'b1;
          next_st.stackData = st.retAddr[7:0];
        end
        if (st.cnt == SAVE_LAST) begin
          next_st.pcLoad = 1'b1;
          next_st.pcValue = st.vec;
          next_st.cnt = 5'h00;
          next_st.state = cihs_pkg::CIHS_RUN;
        end
      end
      cihs_pkg::CIHS_POP: begin
        next_st.cnt = st.cnt + 5'h01;
        if (st.cnt < 5'h02) begin
          next_st.stackPop = 1'b1;
        end
        if (st.cnt == 5'h00) begin
          next_st.popLo = popData;
        end else if (st.cnt == 5'h01) begin
          next_st.popHi = popData;
        end else begin
          next_st.pcLoad = 1'b1;
          next_st.pcValue = {st.popHi, st.popLo};
          next_st.swLoad = 1'b1;
          next_st.swValue = popData;
          next_st.cnt = 5'h00;
          next_st.state = cihs_pkg::CIHS_RUN;
        end
      end
      cihs_pkg::CIHS_HALT: begin
        next_st.cnt = 5'h00;
        if (st.nmiFlag) begin
          nmiClr = 1'b1;
          next_st.ie = 1'b0;
          next_st.vec = `CIHS_VEC_NMI;
          next_st.state = cihs_pkg::CIHS_SAVE;
        end else if (|pend) begin
          if (st.ie) begin
            clrF[idx] = 1'b1;
            next_st.ie = 1'b0;
            next_st.vec = vecOf(idx);
            next_st.state = cihs_pkg::CIHS_SAVE;
          end else begin
            next_st.state = cihs_pkg::CIHS_RUN;
          end
        end
      end
    endcase

    // ----------------------------------------
    // Flag update, set wins over clear
    // ----------------------------------------
    next_st.flags = (st.flags & ~clrF) | setF;
    next_st.nmiFlag = (st.nmiFlag & ~nmiClr) | nmiSet;

    // ----------------------------------------
    // Address latch for the halted bus
    // ----------------------------------------
    if (st.state != cihs_pkg::CIHS_HALT) begin
      next_st.addrHold = addrIn;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.mask <= `CIHS_MASK_RST;
      st.pcValue <= `CIHS_RST_PC;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign haltMode = (st.state == cihs_pkg::CIHS_HALT);
  assign cpuClkEn = (st.state == cihs_pkg::CIHS_RUN);
  assign interruptEnableFf = st.ie;
  assign pcLoad = st.pcLoad;
  assign pcValue = st.pcValue;
  assign swLoad = st.swLoad;
  assign swValue = st.swValue;
  assign stackPush = st.stackPush;
  assign stackData = st.stackData;
  assign stackPop = st.stackPop;
  assign regRdata = st.regRdata;

  // Pins parked while halted in expansion mode
  logic park;
  assign park = haltMode & extMode;
  assign dataOe = dataOeIn & ~park;
  assign wrN = wrNIn | park;
  assign rdN = rdNIn | park;
  assign ale = aleIn | park;
  assign addrOut = park ? st.addrHold : addrIn;

endmodule
`default_nettype wire

//--- rtl/cihs_regs.svh
// What this block does
// - Software trap vectors to 0060H, whatever the enable flip-flop holds, unless the NMI flag is set at its end.
// - Software trap leaves the interrupt enable flip-flop untouched.
// - Trap pushes status word, then PC high byte, then PC low byte.
// - Return pops PC low, PC high, then status word, restoring them.
// - Trap runs despite a met skip condition; stacked status has skip set.
// - Pushed trap return address is the next instruction's start address.
// - NMI and two external inputs pass a 14-state filter; NMI 10 us max.
// - Internal sources set their request flag with no filter delay.
// - Request flags are checked at each instruction's end, and every cycle while in HALT.
// - Automatic save of status word and PC takes 16 states.
// - Enable instruction in a handler allows any request, nesting included.
// - Only the highest-priority request is taken; others stay pending.
// - No hardware nesting depth limit beyond stack memory.
// - Halt enters HALT only with no unmasked request flag set.
// - HALT stops CPU clock only; registers kept, peripherals keep running.
// - Halted in expansion mode: data port floats, address held, write/read/latch strobes high.
// - Reset pin ends HALT; execution restarts at address 0.
// - HALT ends when NMI flag or any unmasked maskable flag sets.
// - NMI release of HALT jumps to 0004H regardless of enable state.
// - Maskable release: disabled resumes after halt, flag stays; enabled vectors.
// - Taking a maskable request clears enable; masked requests are never checked.
`ifndef CIHS_REGS_SVH
`define CIHS_REGS_SVH

// ----------------------------------------
// Register offsets and reset values
// ----------------------------------------
`define CIHS_REG_MASK 2'h0
`define CIHS_REG_FLAGS 2'h1
`define CIHS_REG_STAT 2'h2
`define CIHS_MASK_RST 10'h3ff

// ----------------------------------------
// Vectors and fields
// ----------------------------------------
`define CIHS_VEC_TRAP 16'h0060
`define CIHS_VEC_NMI 16'h0004
`define CIHS_VEC_BASE 16'h0008
`define CIHS_VEC_STEP 16'h0008
`define CIHS_RST_PC 16'h0000
`define CIHS_SK_BIT 5

// ----------------------------------------
// Timing
// ----------------------------------------
`define CIHS_CLK_NS 40
`define CIHS_STATE_CYC 1
`define CIHS_FILT_STATES 14
`define CIHS_NMI_MAX_NS 10000
`define CIHS_SAVE_STATES 16
`define CIHS_FILT_CYC (`CIHS_FILT_STATES * `CIHS_STATE_CYC)
`define CIHS_NMI_MAX_CYC (`CIHS_NMI_MAX_NS / `CIHS_CLK_NS)
`define CIHS_SAVE_CYC (`CIHS_SAVE_STATES * `CIHS_STATE_CYC)

`endif

//--- rtl/cihs_pkg.sv
package cihs_pkg;

  typedef enum logic [1:0] {
    CIHS_RUN = 2'b00,
    CIHS_SAVE = 2'b01,
    CIHS_POP = 2'b10,
    CIHS_HALT = 2'b11
  } cihs_state_t;

  typedef enum logic [2:0] {
    CIHS_K_NONE = 3'b000,
    CIHS_K_TRAP = 3'b001,
    CIHS_K_RETURN_FROM_INTERRUPT_INSTR = 3'b010,
    CIHS_K_HALT = 3'b011,
    CIHS_K_EI = 3'b100,
    CIHS_K_DI = 3'b101
  } cihs_kind_t;

  typedef struct packed {
    cihs_state_t state;
    logic [4:0] cnt;
    logic ie;
    logic nmiFlag;
    logic [9:0] flags;
    logic [9:0] mask;
    logic [2:0][3:0] filt;
    logic [2:0] fired;
    logic [15:0] retAddr;
    logic [7:0] saveSw;
    logic [15:0] vec;
    logic stackPush;
    logic [7:0] stackData;
    logic stackPop;
    logic pcLoad;
    logic [15:0] pcValue;
    logic swLoad;
    logic [7:0] swValue;
    logic [7:0] popLo;
    logic [7:0] popHi;
    logic [15:0] regRdata;
    logic [7:0] addrHold;
  } cihs_st_t;

endpackage

//--- tb/cihs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module cihs_monitor (
  // Clock and core
  input wire logic clock,
  input wire logic rst_n,
  input wire logic instrEnd,
  input wire logic [2:0] instrKind,
  input wire logic [15:0] nextPc,
  input wire logic cpuClkEn,
  input wire logic haltMode,
  input wire logic pcLoad,
  // Stack
  input wire logic stackPush,
  input wire logic [7:0] stackData,
  input wire logic stackPop,
  // Pins
  input wire logic extMode,
  input wire logic dataOeIn,
  input wire logic wrNIn,
  input wire logic rdNIn,
  input wire logic aleIn,
  input wire logic [7:0] addrIn,
  input wire logic dataOe,
  input wire logic wrN,
  input wire logic rdN,
  input wire logic ale,
  input wire logic [7:0] addrOut
);
  logic [15:0] trapPc;
  wire logic hx = haltMode && extMode;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clock) if (instrEnd && cpuClkEn) trapPc <= nextPc;
  sequence s_trap;
    instrEnd && cpuClkEn && instrKind == 3'h1;
  endsequence
  sequence s_three;
    stackPush ##1 stackPush ##1 stackPush ##1 !stackPush;
  endsequence
  property p_halt_pins;
    hx |-> !dataOe && wrN && rdN && ale;
  endproperty
  a_halt_pins: assert property (p_halt_pins) else $error("pins not parked");
  property p_pass;
    !hx |-> dataOe == dataOeIn && wrN == wrNIn && rdN == rdNIn && ale == aleIn
      && addrOut == addrIn;
  endproperty
  a_pass: assert property (p_pass) else $error("pins not passed through");
  property p_addr;
    hx && $past(hx) |-> $stable(addrOut);
  endproperty
  a_addr: assert property (p_addr) else $error("address moved in halt");
  property p_halt_clk;
    haltMode |-> !cpuClkEn && !stackPush && !stackPop && !pcLoad;
  endproperty
  a_halt_clk: assert property (p_halt_clk) else $error("core active in halt");
  property p_push;
    $rose(stackPush) |-> s_three;
  endproperty
  a_push: assert property (p_push) else $error("push count wrong");
  property p_save;
    $rose(stackPush) |-> ##15 pcLoad && cpuClkEn;
  endproperty
  a_save: assert property (p_save) else $error("save length wrong");
  property p_trap_pc;
    s_trap |-> ##3 stackPush && stackData == trapPc[15:8]
      ##1 stackData == trapPc[7:0];
  endproperty
  a_trap_pc: assert property (p_trap_pc) else $error("return pc bytes wrong");
  property p_pop;
    $rose(stackPop) |=> stackPop ##[1:2] pcLoad;
  endproperty
  a_pop: assert property (p_pop) else $error("pop order wrong");
  property p_wake;
    $fell(haltMode) |-> ##[0:17] cpuClkEn;
  endproperty
  a_wake: assert property (p_wake) else $error("clock not restarted");
endmodule
bind cihs_sequencer cihs_monitor cihs_monitor_i (.clock, .rst_n, .instrEnd, .instrKind,
  .nextPc, .cpuClkEn, .haltMode, .pcLoad, .stackPush, .stackData, .stackPop, .extMode,
  .dataOeIn, .wrNIn, .rdNIn, .aleIn, .addrIn, .dataOe, .wrN, .rdN, .ale, .addrOut);
`default_nettype wire

//--- tb/cihs_stack_model.sv
`timescale 1ns/1ps
`default_nettype none
module cihs_stack_model (
  // Stack port
  input wire logic clock,
  input wire logic stackPush,
  input wire logic [7:0] stackData,
  input wire logic stackPop,
  output logic [7:0] popData
);
  logic [7:0] mem [0:63];
  int sp = 0;
  logic [7:0] idle = 8'h00;
  // Top byte shows while the pop strobe stands; inverse of last popped byte otherwise
  assign popData = stackPop ? mem[sp - 1] : idle;
  always @(posedge clock) begin
    if (stackPush) begin
      mem[sp] <= stackData;
      sp <= sp + 1;
    end else if (stackPop) begin
      idle <= ~mem[sp - 1];
      sp <= sp - 1;
    end
  end
endmodule
`default_nettype wire

//--- tb/tb_cihs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_cihs_sequencer;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic instrEnd = 1'b0;
  logic [2:0] instrKind = 3'h0;
  logic [15:0] nextPc = 16'h0000;
  logic [7:0] statusWord = 8'h00;
  logic skipPending = 1'b0;
  logic nmiN = 1'b1;
  logic extIrqA = 1'b0;
  logic extIrqBN = 1'b1;
  logic [7:0] periphReq = 8'h00;
  logic [1:0] regAddr = 2'h0;
  logic [15:0] regWdata = 16'h0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic extMode = 1'b1;
  logic [7:0] addrIn = 8'h5a;
  logic cpuClkEn, haltMode, interruptEnableFf, pcLoad, swLoad, stackPush, stackPop;
  logic dataOe, wrN, rdN, ale;
  logic [15:0] pcValue, regRdata, v;
  logic [7:0] swValue, stackData, popData, addrOut;
  int mismatches = 0;
  int tests_run = 0;
  int base;
  always #20 clock = ~clock;
  cihs_sequencer cihs_sequencer_i (.clock, .rst_n, .instrEnd, .instrKind, .nextPc,
    .statusWord, .skipPending, .cpuClkEn, .haltMode, .interruptEnableFf, .pcLoad,
    .pcValue, .swLoad, .swValue, .stackPush, .stackData, .stackPop, .popData, .nmiN,
    .extIrqA, .extIrqBN, .periphReq, .regAddr, .regWdata, .regWr, .regRd,
    .regRdata, .extMode, .dataOeIn(1'b1), .wrNIn(1'b0), .rdNIn(1'b0), .aleIn(1'b0),
    .addrIn, .dataOe, .wrN, .rdN, .ale, .addrOut);
  cihs_stack_model stk_i (.clock, .stackPush, .stackData, .stackPop, .popData);
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic rd(input logic [1:0] a);
    @(posedge clock);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRd <= 1'b0;
    #1 v = regRdata;
  endtask
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clock);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clock);
    regWr <= 1'b0;
  endtask
  task automatic ins(input logic [2:0] k, input logic [15:0] pc, input logic [7:0] s,
    input logic sk);
    @(posedge clock);
    instrEnd <= 1'b1;
    instrKind <= k;
    nextPc <= pc;
    statusWord <= s;
    skipPending <= sk;
    @(posedge clock);
    instrEnd <= 1'b0;
  endtask
  task automatic waitLoad();
    for (int i = 0; i < 40 && pcLoad !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    chk("pcLoad", pcLoad, 1'b1);
    v = pcValue;
  endtask
  task automatic t_trap();
    base = stk_i.sp;
    ins(3'h4, 16'h0000, 8'h00, 1'b0);
    ins(3'h1, 16'h1234, 8'h81, 1'b1);
    waitLoad();
    chk("trap vector", v, 16'h0060);
    ins(3'h1, 16'h0062, 8'h00, 1'b0);
    waitLoad();
    chk("ie kept", interruptEnableFf, 1'b1);
    chk("sw pushed", stk_i.mem[base], 8'ha1);
    chk("pc hi", stk_i.mem[base + 1], 8'h12);
    chk("pc lo", stk_i.mem[base + 2], 8'h34);
    chk("nested sw", stk_i.mem[base + 3], 8'h00);
    ins(3'h2, 16'h0000, 8'h00, 1'b0);
    waitLoad();
    chk("inner return", v, 16'h0062);
    ins(3'h2, 16'h0000, 8'h00, 1'b0);
    waitLoad();
    chk("outer return", v, 16'h1234);
    chk("sw restored", swValue, 8'ha1);
    chk("sw load", swLoad, 1'b1);
    $display("trap test done");
  endtask
  task automatic t_irq();
    @(posedge clock);
    periphReq <= 8'h09;
    @(posedge clock);
    periphReq <= 8'h00;
    ins(3'h0, 16'h0100, 8'h00, 1'b0);
    rd(2'h1);
    chk("masked flags", v, 16'h0024);
    wr(2'h0, 16'h03db);
    @(posedge clock);
    #1 chk("wait for boundary", cpuClkEn, 1'b1);
    ins(3'h0, 16'h0200, 8'h00, 1'b0);
    waitLoad();
    chk("first vector", v, 16'h0018);
    chk("ie cleared", interruptEnableFf, 1'b0);
    rd(2'h1);
    chk("pending", v, 16'h0020);
    ins(3'h4, 16'h0000, 8'h00, 1'b0);
    ins(3'h0, 16'h0300, 8'h00, 1'b0);
    waitLoad();
    chk("nested vector", v, 16'h0030);
    $display("irq test done");
  endtask
  task automatic t_filt(input int n, input logic b, input logic [15:0] exp);
    @(posedge clock);
    if (b) begin
      extIrqBN <= 1'b0;
    end else begin
      extIrqA <= 1'b1;
    end
    repeat (n) @(posedge clock);
    extIrqA <= 1'b0;
    extIrqBN <= 1'b1;
    rd(2'h1);
    chk("filtered flag", v, exp);
    wr(2'h1, 16'h07ff);
    $display("filter test done");
  endtask
  task automatic t_halt();
    ins(3'h3, 16'h0400, 8'h00, 1'b0);
    addrIn <= 8'ha5;
    periphReq <= 8'h02;
    @(posedge clock);
    periphReq <= 8'h00;
    repeat (3) @(posedge clock);
    #1 chk("halted", haltMode, 1'b1);
    chk("addr held", addrOut, 8'h5a);
    rd(2'h2);
    chk("status halted", v, 16'h000d);
    @(posedge clock);
    periphReq <= 8'h01;
    @(posedge clock);
    periphReq <= 8'h00;
    repeat (3) @(posedge clock);
    #1 chk("resumed", cpuClkEn, 1'b1);
    chk("no vector", pcLoad, 1'b0);
    ins(3'h3, 16'h0400, 8'h00, 1'b0);
    #1 chk("halt refused", haltMode, 1'b0);
    rd(2'h1);
    chk("flag kept", v, 16'h000c);
    wr(2'h1, 16'h07ff);
    ins(3'h3, 16'h0500, 8'h00, 1'b0);
    nmiN <= 1'b0;
    waitLoad();
    @(posedge clock);
    nmiN <= 1'b1;
    chk("nmi vector", v, 16'h0004);
    ins(3'h3, 16'h0600, 8'h00, 1'b0);
    #1 chk("halted again", haltMode, 1'b1);
    @(posedge clock);
    rst_n <= 1'b0;
    @(posedge clock);
    #1 chk("reset ends halt", haltMode, 1'b0);
    chk("reset pc", pcValue, 16'h0000);
    @(posedge clock);
    rst_n <= 1'b1;
    $display("halt test done");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    t_trap();
    t_irq();
    t_filt(13, 1'b0, 16'h0000);
    t_filt(14, 1'b0, 16'h0001);
    t_filt(13, 1'b1, 16'h0000);
    t_filt(14, 1'b1, 16'h0002);
    t_halt();
    close_out();
  end
  initial begin
    #200000;
    mismatches++;
    close_out();
  end
endmodule
`default_nettype wire
